// *** rtl/pin_readback_pkg.sv ***
// Constants for the eight-pin port with timer and pattern sharing
package pin_readback_pkg;
	// ------------------------------------------------------------
	// Register map (lower 16 bits of the address)
	// ------------------------------------------------------------
	localparam logic [15:0] ADDR_PORT_DIRECTION = 16'hFEB0;
	localparam logic [15:0] ADDR_PORT_PIN_LEVELS = 16'hFF50;
	localparam logic [15:0] ADDR_PORT_OUTPUT_LATCH = 16'hFF60;
	localparam logic [7:0] RST_PORT_DIRECTION = 8'h00;
	localparam logic [7:0] RST_PORT_OUTPUT_LATCH = 8'h00;
	// Value returned by a read of the write-only direction register
	localparam logic [7:0] DIRECTION_READ_VALUE = 8'hFF;
	// Value returned by an unmapped read
	localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

	// ------------------------------------------------------------
	// Pin positions
	// ------------------------------------------------------------
	localparam int PIN_A0 = 0;
	localparam int PIN_B0 = 1;
	localparam int PIN_C0 = 2;
	localparam int PIN_D0 = 3;
	localparam int PIN_A1 = 4;
	localparam int PIN_B1 = 5;
	localparam int PIN_A2 = 6;
	localparam int PIN_B2 = 7;

	// ------------------------------------------------------------
	// Timer setting codes
	// ------------------------------------------------------------
	localparam logic [3:0] MODE_NORMAL = 4'h0;
	localparam logic [3:0] MODE_PWM1 = 4'h2;
	localparam logic [3:0] MODE_PWM2 = 4'h3;
	localparam logic [1:0] MODE_PHASE_TOP = 2'h1;
	localparam logic [1:0] IOC_CAPTURE_TOP = 2'h2;
	localparam logic [1:0] IOC_OFF_LOW = 2'h0;
	localparam logic [2:0] PSC_CLOCK_A = 3'h4;
	localparam logic [2:0] PSC_CLOCK_B = 3'h5;
	localparam logic [2:0] PSC_CLOCK_C = 3'h6;
	localparam logic [2:0] PSC_CLOCK_C_HIGH = 3'h5;
	localparam logic [2:0] PSC_CLOCK_D = 3'h7;
	localparam logic [2:0] CCLR0_A = 3'h1;
	localparam logic [2:0] CCLR0_B = 3'h2;
	localparam logic [2:0] CCLR0_C = 3'h5;
	localparam logic [2:0] CCLR0_D = 3'h6;
	localparam logic [1:0] CCLR12_A = 2'h1;
	localparam logic [1:0] CCLR12_B = 2'h2;
endpackage

// *** rtl/pin_decode_if.sv ***
// Interface between the port and one timer pin decoder
`timescale 1ns/1ps
`default_nettype none
interface pin_decode_if;
	logic [3:0] mode;
	logic [3:0] io_ctl;
	logic own_clear;
	logic blocked;
	logic drive_en;
	logic capture_en;
	modport decoder (
		input mode,
		input io_ctl,
		input own_clear,
		input blocked,
		output drive_en,
		output capture_en
	);
	modport owner (
		output mode,
		output io_ctl,
		output own_clear,
		output blocked,
		input drive_en,
		input capture_en
	);
endinterface
`default_nettype wire

// *** rtl/timer_pin_decode.sv ***
// Decodes one shared timer pin into output and capture enables
`timescale 1ns/1ps
`default_nettype none
module timer_pin_decode #(
	parameter bit IS_CH0 = 1'b0,
	parameter bit IS_AC = 1'b0
) (
	pin_decode_if.decoder dec
);
	logic normal_mode;
	logic compare_code;
	logic active_code;
	logic oc_out;
	logic pwm1_out;
	logic pwm2_out;

	// ------------------------------------------------------------
	// Mode and code decode
	// ------------------------------------------------------------
	always_comb begin
		if (IS_CH0) begin
			normal_mode = (dec.mode == pin_readback_pkg::MODE_NORMAL);
		end else begin
			normal_mode = (dec.mode == pin_readback_pkg::MODE_NORMAL) ||
				(dec.mode[3:2] == pin_readback_pkg::MODE_PHASE_TOP);
		end
	end

	assign active_code = (dec.io_ctl[1:0] != pin_readback_pkg::IOC_OFF_LOW);
	assign compare_code = !dec.io_ctl[3] && active_code;
	assign oc_out = normal_mode && compare_code;
	// B and D pins never drive in PWM mode 1: their partner owns the period
	assign pwm1_out = IS_AC && (dec.mode == pin_readback_pkg::MODE_PWM1) && active_code;
	assign pwm2_out = (dec.mode == pin_readback_pkg::MODE_PWM2) && active_code && !dec.own_clear;
	assign dec.drive_en = (oc_out || pwm1_out || pwm2_out) && !dec.blocked;

	always_comb begin
		if (IS_CH0) begin
			dec.capture_en = (dec.mode == pin_readback_pkg::MODE_NORMAL) &&
				(dec.io_ctl[3:2] == pin_readback_pkg::IOC_CAPTURE_TOP);
		end else begin
			dec.capture_en = normal_mode && dec.io_ctl[3];
		end
	end
endmodule // timer_pin_decode
`default_nettype wire

// *** rtl/pin_readback_gpio.sv ***
// Eight-pin port shared with timer pins, pattern outputs and clock inputs
// Notes on behaviour
// - Direction bit 1 makes the pin an output, 0 an input.
// - Direction register is write-only; its read returns a fixed meaningless value.
// - Direction clears on reset and hardware standby, kept in software standby.
// - Output latch is read/write, clears on reset and hardware standby.
// - Pin register is read-only; writes to it are ignored.
// - Pin register read gives latch value where direction is 1.
// - Pin register read gives sampled pin level where direction is 0.
// - Pin register follows pins after reset, frozen during software standby unless hardware standby is active.
// - Selection is the same in every operating mode.
// - Timer output first, else input by direction, else pattern output where enabled, else latch.
// - Channels 1 and 2 capture in normal or phase mode when input selected.
// - Channel 0 captures only in normal mode with I/O code 10xx.
// - Compare output for I/O codes 0001-0011 and 0101-0111 in normal mode.
// - PWM mode 1 drives A or C pins; paired B or D pin stays off.
// - PWM mode 2 drives unless the counter clears on that pin's register.
// - Clock input A on prescaler 100 anywhere, or channels 1 and 5 phase mode.
// - Clock B on channel 0-2 prescaler 101; clock D on channel 0/5 prescaler 111 or phase mode.
// - Clock C on channel 0/2 code 110, channel 4/5 code 101, or phase mode.
// - Channel 0 buffer mode disables the C-pin timer output.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module pin_readback_gpio (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Power states
	input wire logic hw_standby_n,
	input wire logic sw_standby,
	// Register port
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Port pins
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe_n,
	// Timer settings
	input wire logic [5:0][3:0] channel_mode_field,
	input wire logic [5:0][2:0] prescaler_select,
	input wire logic [7:0][3:0] pin_io_control,
	input wire logic [2:0] counter_clear_select_ch0,
	input wire logic [1:0] counter_clear_select_ch1,
	input wire logic [1:0] counter_clear_select_ch2,
	input wire logic buffer_mode_a,
	input wire logic buffer_mode_b,
	// Timer and pattern data
	input wire logic [7:0] timer_io_out,
	input wire logic [7:0] pattern_output_pin,
	input wire logic [7:0] pattern_enable_high,
	// Timer inputs
	output logic [7:0] capture_level,
	output logic [7:0] capture_en,
	output logic ext_clock_a,
	output logic ext_clock_b,
	output logic ext_clock_c,
	output logic ext_clock_d,
	output logic ext_clock_a_en,
	output logic ext_clock_b_en,
	output logic ext_clock_c_en,
	output logic ext_clock_d_en
);
	logic [7:0] direction_bits;
	logic [7:0] output_latch;
	logic [7:0] pin_readback;
	logic [7:0] pin_meta_reg;
	logic [7:0] pin_sync_reg;
	logic hws_meta_reg;
	logic hws_sync_reg;
	logic hw_standby;
	logic [7:0] timer_drive;
	logic [7:0] own_clear;
	logic [7:0] pin_out_next;
	logic [7:0] pin_oe_n_next;
	logic [7:0] rdata_next;
	logic [5:0] phase_mode;
	logic [5:0] psc_a;
	logic [5:0] psc_b;
	logic [5:0] psc_c;
	logic [5:0] psc_c_high;
	logic [5:0] psc_d;

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_reg <= 8'h00;
			pin_sync_reg <= 8'h00;
		end else begin
			pin_meta_reg <= pin_in;
			pin_sync_reg <= pin_meta_reg;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hws_meta_reg <= 1'b1;
			hws_sync_reg <= 1'b1;
		end else begin
			hws_meta_reg <= hw_standby_n;
			hws_sync_reg <= hws_meta_reg;
		end
	end

	assign hw_standby = !hws_sync_reg;

	// ------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			direction_bits <= pin_readback_pkg::RST_PORT_DIRECTION;
		end else if (hw_standby) begin
			direction_bits <= pin_readback_pkg::RST_PORT_DIRECTION;
		end else if (reg_wr && reg_addr == pin_readback_pkg::ADDR_PORT_DIRECTION) begin
			direction_bits <= reg_wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			output_latch <= pin_readback_pkg::RST_PORT_OUTPUT_LATCH;
		end else if (hw_standby) begin
			output_latch <= pin_readback_pkg::RST_PORT_OUTPUT_LATCH;
		end else if (reg_wr && reg_addr == pin_readback_pkg::ADDR_PORT_OUTPUT_LATCH) begin
			output_latch <= reg_wdata;
		end
	end

	// Pin sampling stops in software standby, unless hardware standby is active, so the last levels are kept
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_readback <= 8'h00;
		end else if (!sw_standby || hw_standby) begin
			pin_readback <= pin_sync_reg;
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	always_comb begin
		rdata_next = pin_readback_pkg::UNMAPPED_READ_VALUE;
		case (reg_addr)
			pin_readback_pkg::ADDR_PORT_DIRECTION: begin
				rdata_next = pin_readback_pkg::DIRECTION_READ_VALUE;
			end
			pin_readback_pkg::ADDR_PORT_OUTPUT_LATCH: begin
				rdata_next = output_latch;
			end
			pin_readback_pkg::ADDR_PORT_PIN_LEVELS: begin
				rdata_next = (direction_bits & output_latch) | (~direction_bits & pin_readback);
			end
			default: begin
				rdata_next = pin_readback_pkg::UNMAPPED_READ_VALUE;
			end
		endcase
	end

	// Writes to the pin register address have no target and are dropped
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rdata_next;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ------------------------------------------------------------
	// Timer pin decoders
	// ------------------------------------------------------------
	assign own_clear[pin_readback_pkg::PIN_A0] = (counter_clear_select_ch0 == pin_readback_pkg::CCLR0_A);
	assign own_clear[pin_readback_pkg::PIN_B0] = (counter_clear_select_ch0 == pin_readback_pkg::CCLR0_B);
	assign own_clear[pin_readback_pkg::PIN_C0] = (counter_clear_select_ch0 == pin_readback_pkg::CCLR0_C);
	assign own_clear[pin_readback_pkg::PIN_D0] = (counter_clear_select_ch0 == pin_readback_pkg::CCLR0_D);
	assign own_clear[pin_readback_pkg::PIN_A1] = (counter_clear_select_ch1 == pin_readback_pkg::CCLR12_A);
	assign own_clear[pin_readback_pkg::PIN_B1] = (counter_clear_select_ch1 == pin_readback_pkg::CCLR12_B);
	assign own_clear[pin_readback_pkg::PIN_A2] = (counter_clear_select_ch2 == pin_readback_pkg::CCLR12_A);
	assign own_clear[pin_readback_pkg::PIN_B2] = (counter_clear_select_ch2 == pin_readback_pkg::CCLR12_B);

	// Pins 0-3 belong to channel 0, 4-5 to channel 1, 6-7 to channel 2
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_pin
			localparam int CH = (gi < 4) ? 0 : ((gi < 6) ? 1 : 2);
			localparam bit AC = (gi == pin_readback_pkg::PIN_A0) || (gi == pin_readback_pkg::PIN_C0) ||
				(gi == pin_readback_pkg::PIN_A1) || (gi == pin_readback_pkg::PIN_A2);
			pin_decode_if dif ();
			assign dif.mode = channel_mode_field[CH];
			assign dif.io_ctl = pin_io_control[gi];
			assign dif.own_clear = own_clear[gi];
			if (gi == pin_readback_pkg::PIN_C0) begin : g_buf
				assign dif.blocked = buffer_mode_a || buffer_mode_b;
			end else begin : g_nobuf
				assign dif.blocked = 1'b0;
			end
			timer_pin_decode #(
				.IS_CH0(CH == 0),
				.IS_AC(AC)
			) u_dec (
				.dec(dif.decoder)
			);
			assign timer_drive[gi] = dif.drive_en;
			assign capture_en[gi] = dif.capture_en;
		end
	endgenerate

	// ------------------------------------------------------------
	// Pin drive selection, no dependence on operating mode
	// ------------------------------------------------------------
	// Which source owns each pin this cycle
	typedef enum logic [1:0] {
		SRC_INPUT = 2'h0,
		SRC_LATCH = 2'h1,
		SRC_PATTERN = 2'h2,
		SRC_TIMER = 2'h3
	} pin_src_e;

	pin_src_e pin_src [8];

	// Timer output outranks the direction bit
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (timer_drive[i]) begin
				pin_src[i] = SRC_TIMER;
			end else if (!direction_bits[i]) begin
				pin_src[i] = SRC_INPUT;
			end else if (pattern_enable_high[i]) begin
				pin_src[i] = SRC_PATTERN;
			end else begin
				pin_src[i] = SRC_LATCH;
			end
		end
	end

	// The operating mode never reaches this mux
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			case (pin_src[i])
				SRC_TIMER: begin
					pin_out_next[i] = timer_io_out[i];
					pin_oe_n_next[i] = 1'b0;
				end
				SRC_PATTERN: begin
					pin_out_next[i] = pattern_output_pin[i];
					pin_oe_n_next[i] = 1'b0;
				end
				SRC_LATCH: begin
					pin_out_next[i] = output_latch[i];
					pin_oe_n_next[i] = 1'b0;
				end
				default: begin
					pin_out_next[i] = 1'b0;
					pin_oe_n_next[i] = 1'b1;
				end
			endcase
		end
	end

	// Drive value and enable move together on the edge after a setting change
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_out <= 8'h00;
		end else begin
			pin_out <= pin_out_next;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_oe_n <= 8'hFF;
		end else begin
			pin_oe_n <= pin_oe_n_next;
		end
	end

	assign capture_level = pin_sync_reg;

	// ------------------------------------------------------------
	// External clock inputs
	// ------------------------------------------------------------
	always_comb begin
		for (int c = 0; c < 6; c++) begin
			phase_mode[c] = (channel_mode_field[c][3:2] == pin_readback_pkg::MODE_PHASE_TOP);
			psc_a[c] = (prescaler_select[c] == pin_readback_pkg::PSC_CLOCK_A);
			psc_b[c] = (prescaler_select[c] == pin_readback_pkg::PSC_CLOCK_B);
			psc_c[c] = (prescaler_select[c] == pin_readback_pkg::PSC_CLOCK_C);
			psc_c_high[c] = (prescaler_select[c] == pin_readback_pkg::PSC_CLOCK_C_HIGH);
			psc_d[c] = (prescaler_select[c] == pin_readback_pkg::PSC_CLOCK_D);
		end
	end

	// Clock A: its code on any channel, or phase counting on channel 1 or 5
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_clock_a_en <= 1'b0;
		end else begin
			ext_clock_a_en <= (|psc_a) || phase_mode[1] || phase_mode[5];
		end
	end

	// Clock B: its code on channels 0-2, or the same phase pair as clock A
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_clock_b_en <= 1'b0;
		end else begin
			ext_clock_b_en <= (|psc_b[2:0]) || phase_mode[1] || phase_mode[5];
		end
	end

	// Clock C: two codes on two channel pairs, or phase counting on channel 2 or 4
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_clock_c_en <= 1'b0;
		end else begin
			ext_clock_c_en <= psc_c[0] || psc_c[2] || psc_c_high[4] || psc_c_high[5] ||
				phase_mode[2] || phase_mode[4];
		end
	end

	// Clock D: its code on channel 0 or 5, or the same phase pair as clock C
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_clock_d_en <= 1'b0;
		end else begin
			ext_clock_d_en <= psc_d[0] || psc_d[5] || phase_mode[2] || phase_mode[4];
		end
	end

	assign ext_clock_a = pin_sync_reg[pin_readback_pkg::PIN_C0];
	assign ext_clock_b = pin_sync_reg[pin_readback_pkg::PIN_D0];
	assign ext_clock_c = pin_sync_reg[pin_readback_pkg::PIN_B1];
	assign ext_clock_d = pin_sync_reg[pin_readback_pkg::PIN_B2];
endmodule // pin_readback_gpio
`default_nettype wire

// *** tb/pin_partner.sv ***
// External circuitry that loads the eight port pins
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
	// Port side
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe_n,
	// Levels the outside world drives on released pins
	input wire logic [7:0] ext_level,
	// Wire level seen by the port
	output logic [7:0] pin_in
);
	// Outside driver backs off wherever the port drives, so no contention
	assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_level);
endmodule // pin_partner
`default_nettype wire

// *** tb/pin_readback_properties.sv ***
// Concurrent checks on the shared port's top-level pins
`timescale 1ns/1ps
`default_nettype none
module pin_readback_properties (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire logic [15:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Pins and timer side
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe_n,
	input wire logic [5:0][3:0] channel_mode_field,
	input wire logic [5:0][2:0] prescaler_select,
	input wire logic [7:0][3:0] pin_io_control,
	input wire logic [2:0] counter_clear_select_ch0,
	input wire logic [7:0] timer_io_out,
	input wire logic [7:0] capture_en,
	input wire logic ext_clock_a_en,
	input wire logic ext_clock_b_en,
	input wire logic ext_clock_c_en
);
	// ------------------------------------------------------------
	// Helpers and properties
	// ------------------------------------------------------------
	logic psc_a;
	always_comb begin
		psc_a = 1'b0;
		for (int i = 0; i < 6; i++)
			psc_a = psc_a | (prescaler_select[i] == 3'h4);
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_dir_read;
		reg_rd && reg_addr == 16'hFEB0 |=> reg_rdata == pin_readback_pkg::DIRECTION_READ_VALUE;
	endproperty
	a_dir_read: assert property (p_dir_read) else $error("direction read");
	property p_cmp_a1;
		channel_mode_field[1] == 4'h0 && !pin_io_control[4][3] && pin_io_control[4][1:0] != 2'h0
			|=> !pin_oe_n[4] && pin_out[4] == $past(timer_io_out[4]);
	endproperty
	a_cmp_a1: assert property (p_cmp_a1) else $error("compare output");
	property p_pwm1_a0;
		channel_mode_field[0] == 4'h2 && pin_io_control[0][1:0] != 2'h0
			|=> !pin_oe_n[0] && pin_out[0] == $past(timer_io_out[0]);
	endproperty
	a_pwm1_a0: assert property (p_pwm1_a0) else $error("pwm1 output");
	property p_pwm2_a0;
		channel_mode_field[0] == 4'h3 && pin_io_control[0][1:0] != 2'h0
			&& counter_clear_select_ch0 != 3'h1
			|=> !pin_oe_n[0] && pin_out[0] == $past(timer_io_out[0]);
	endproperty
	a_pwm2_a0: assert property (p_pwm2_a0) else $error("pwm2 output");
	property p_cap_a0;
		channel_mode_field[0] == 4'h0 |-> capture_en[0] == (pin_io_control[0][3:2] == 2'h2);
	endproperty
	a_cap_a0: assert property (p_cap_a0) else $error("capture pin a0");
	property p_cap_b2;
		channel_mode_field[2] == 4'h0 || channel_mode_field[2][3:2] == 2'h1
			|-> capture_en[7] == pin_io_control[7][3];
	endproperty
	a_cap_b2: assert property (p_cap_b2) else $error("capture pin b2");
	property p_clk_a;
		psc_a |=> ext_clock_a_en;
	endproperty
	a_clk_a: assert property (p_clk_a) else $error("clock a select");
	property p_clk_b;
		prescaler_select[0] == 3'h5 || prescaler_select[1] == 3'h5 || prescaler_select[2] == 3'h5
			|=> ext_clock_b_en;
	endproperty
	a_clk_b: assert property (p_clk_b) else $error("clock b select");
	property p_clk_c;
		prescaler_select[0] == 3'h6 || prescaler_select[2] == 3'h6
			|| prescaler_select[4] == 3'h5 || prescaler_select[5] == 3'h5 |=> ext_clock_c_en;
	endproperty
	a_clk_c: assert property (p_clk_c) else $error("clock c select");
	c_read: cover property (reg_rd ##1 reg_rdata != 8'h00);
	c_cap: cover property (capture_en[0]);
	c_clk: cover property (ext_clock_c_en);
endmodule // pin_readback_properties
bind pin_readback_gpio pin_readback_properties chk (.clk, .rst_n, .reg_addr, .reg_rd, .reg_rdata,
	.pin_out, .pin_oe_n, .channel_mode_field, .prescaler_select, .pin_io_control,
	.counter_clear_select_ch0, .timer_io_out, .capture_en, .ext_clock_a_en,
	.ext_clock_b_en, .ext_clock_c_en);
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the eight-pin shared port
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
	$display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module tb;
	logic clk, rst_n, hw_standby_n, sw_standby, reg_wr, reg_rd, buffer_mode_a, buffer_mode_b;
	logic [15:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, pin_in, pin_out, pin_oe_n, ext_level, rd_val;
	logic [7:0] timer_io_out, pattern_output_pin, pattern_enable_high, capture_en;
	logic [5:0][3:0] mode;
	logic [5:0][2:0] psc;
	logic [7:0][3:0] ioc;
	logic [2:0] ccs0;
	logic [3:0] clk_en, ext_clk;
	logic [7:0] cap_level;
	int failures = 0;
	int n_compared = 0;
	pin_readback_gpio uut (.clk, .rst_n, .hw_standby_n, .sw_standby, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .pin_in, .pin_out, .pin_oe_n, .channel_mode_field(mode),
		.prescaler_select(psc), .pin_io_control(ioc), .counter_clear_select_ch0(ccs0),
		.counter_clear_select_ch1(2'h0), .counter_clear_select_ch2(2'h0), .buffer_mode_a,
		.buffer_mode_b, .timer_io_out, .pattern_output_pin, .pattern_enable_high,
		.capture_level(cap_level), .capture_en, .ext_clock_a(ext_clk[0]),
		.ext_clock_b(ext_clk[1]), .ext_clock_c(ext_clk[2]), .ext_clock_d(ext_clk[3]),
		.ext_clock_a_en(clk_en[0]), .ext_clock_b_en(clk_en[1]),
		.ext_clock_c_en(clk_en[2]), .ext_clock_d_en(clk_en[3]));
	pin_partner ext (.pin_out, .pin_oe_n, .ext_level, .pin_in);
	// ------------------------------------------------------------
	// Bus and timing helpers
	// ------------------------------------------------------------
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rd_val = reg_rdata;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic complete_run;
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs;
		rd(16'hFF60);
		`CHK(rd_val, 8'h00)
		`CHK(pin_oe_n, 8'hFF)
		rd(16'hFEB0);
		`CHK(rd_val, pin_readback_pkg::DIRECTION_READ_VALUE)
		wr(16'hFF60, 8'hA5);
		wr(16'hFEB0, 8'h0F);
		wr(16'hFF50, 8'hFF);
		wr(16'h1234, 8'hFF);
		rd(16'h1234);
		`CHK(rd_val, 8'h00)
		rd(16'hFF60);
		`CHK(rd_val, 8'hA5)
		settle(4);
		`CHK({pin_oe_n, pin_out[3:0]}, 12'hF05)
		rd(16'hFF50);
		`CHK(rd_val, 8'h35)
		`CHK({cap_level, ext_clk}, 12'h355)
	endtask
	task automatic t_standby;
		@(posedge clk);
		sw_standby <= 1'b1;
		ext_level <= 8'hC3;
		settle(5);
		rd(16'hFF50);
		`CHK(rd_val, 8'h35)
		@(posedge clk);
		sw_standby <= 1'b0;
		settle(5);
		rd(16'hFF50);
		`CHK(rd_val, 8'hC5)
		`CHK(pin_oe_n, 8'hF0)
		@(posedge clk);
		hw_standby_n <= 1'b0;
		settle(6);
		`CHK(pin_oe_n, 8'hFF)
		rd(16'hFF60);
		`CHK(rd_val, 8'h00)
		rd(16'hFF50);
		`CHK(rd_val, 8'hC3)
		`CHK({cap_level, ext_clk}, 12'hC38)
		@(posedge clk);
		hw_standby_n <= 1'b1;
		settle(4);
	endtask
	task automatic t_pattern;
		wr(16'hFF60, 8'h80);
		wr(16'hFEB0, 8'h80);
		@(posedge clk);
		pattern_enable_high <= 8'h80;
		settle(3);
		`CHK({pin_oe_n[7], pin_out[7]}, 2'b00)
		@(posedge clk);
		pattern_enable_high <= 8'h00;
		settle(2);
		`CHK(pin_out[7], 1'b1)
		wr(16'hFEB0, 8'h00);
	endtask
	task automatic t_timer;
		for (int c = 0; c < 16; c++) begin
			@(posedge clk);
			ioc[4] <= 4'(c);
			timer_io_out <= 8'h10;
			settle(2);
			`CHK({pin_oe_n[4], pin_out[4]}, (c < 8 && c % 4 != 0) ? 2'b01 : 2'b10)
		end
	endtask
	task automatic t_pwm;
		@(posedge clk);
		mode <= 24'h000002;
		ioc <= 32'h00000011;
		settle(2);
		`CHK(pin_oe_n[1:0], 2'b10)
		@(posedge clk);
		mode <= 24'h000003;
		ioc <= 32'h00001001;
		ccs0 <= 3'h6;
		settle(2);
		`CHK(pin_oe_n[3], 1'b1)
		@(posedge clk);
		ccs0 <= 3'h0;
		settle(2);
		`CHK(pin_oe_n[3], 1'b0)
	endtask
	task automatic t_buffer;
		@(posedge clk);
		mode <= '0;
		ioc <= 32'h00000100;
		settle(2);
		`CHK(pin_oe_n[2], 1'b0)
		@(posedge clk);
		buffer_mode_a <= 1'b1;
		settle(2);
		`CHK(pin_oe_n[2], 1'b1)
		@(posedge clk);
		buffer_mode_a <= 1'b0;
		buffer_mode_b <= 1'b1;
		settle(2);
		`CHK(pin_oe_n[2], 1'b1)
	endtask
	task automatic t_capture;
		@(posedge clk);
		ioc <= 32'h80000008;
		settle(1);
		`CHK({capture_en[7], capture_en[0]}, 2'b11)
		@(posedge clk);
		ioc <= 32'h8000000C;
		mode <= 24'h000400;
		settle(1);
		`CHK({capture_en[7], capture_en[0]}, 2'b10)
	endtask
	task automatic clk_case(input int ch, input logic [2:0] p, input logic [3:0] m,
		input logic [3:0] e);
		logic [5:0][2:0] pv;
		logic [5:0][3:0] mv;
		pv = '0;
		mv = '0;
		pv[ch] = p;
		mv[ch] = m;
		@(posedge clk);
		psc <= pv;
		mode <= mv;
		settle(2);
		`CHK(clk_en, e)
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		{rst_n, sw_standby, reg_wr, reg_rd, buffer_mode_a, buffer_mode_b} = '0;
		hw_standby_n = 1'b1;
		{reg_addr, reg_wdata, timer_io_out, pattern_output_pin, pattern_enable_high} = '0;
		{mode, psc, ioc, ccs0} = '0;
		ext_level = 8'h3C;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_regs;
		t_standby;
		t_pattern;
		t_timer;
		t_pwm;
		t_buffer;
		t_capture;
		clk_case(3, 3'h4, 4'h0, 4'b0001);
		clk_case(1, 3'h0, 4'h4, 4'b0011);
		clk_case(2, 3'h5, 4'h0, 4'b0010);
		clk_case(5, 3'h7, 4'h0, 4'b1000);
		clk_case(2, 3'h0, 4'h4, 4'b1100);
		clk_case(0, 3'h6, 4'h0, 4'b0100);
		clk_case(4, 3'h5, 4'h0, 4'b0100);
		complete_run;
	end
	initial begin
		#200000;
		failures++;
		complete_run;
	end
endmodule // tb
`default_nettype wire
